// ---- pms_pkg.sv ----
// constants, field layout and state type of the transceiver mode and status registers
package pms_pkg;

  // -----------------------------------------------------------------
  // register indices
  // -----------------------------------------------------------------
  localparam logic [4:0] IDX_AN_EXPANSION  = 5'h06;
  localparam logic [4:0] IDX_MODE_CONTROL  = 5'h11;
  localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
  localparam logic [4:0] IDX_CROSSOVER     = 5'h1B;
  localparam logic [4:0] IDX_INT_SOURCE    = 5'h1D;
  localparam logic [4:0] IDX_INT_MASK      = 5'h1E;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int EXP_PARTNER_AN   = 0;
  localparam int EXP_PAGE_RX      = 1;
  localparam int EXP_LOCAL_NP     = 2;
  localparam int EXP_PARTNER_NP   = 3;
  localparam int EXP_PD_FAULT     = 4;
  localparam int MC_ENERGY        = 1;
  localparam int MC_EDPD          = 13;
  localparam int SM_ADDR_LSB      = 0;
  localparam int SM_MODE_LSB      = 5;
  localparam int XO_OVERRIDE      = 15;
  localparam int XO_AUTO          = 14;
  localparam int XO_SWAP          = 13;
  localparam int XO_PLL_REF       = 10;
  localparam int XO_POLARITY      = 4;
  localparam int INT_ENERGY       = 7;
  localparam int INT_AN_DONE      = 6;
  localparam int INT_REMOTE_FAULT = 5;
  localparam int INT_LINK_DOWN    = 4;
  localparam int INT_PARTNER_ACK  = 3;
  localparam int INT_PD_FAULT     = 2;
  localparam int INT_PAGE_RX      = 1;

  // -----------------------------------------------------------------
  // write masks and reset values
  // -----------------------------------------------------------------
  localparam logic [15:0] MC_WRITE_MASK  = 16'hFFFD;
  localparam logic [15:0] XO_WRITE_MASK  = 16'hFFE0;
  localparam logic [15:0] XO_KEPT_MASK   = 16'h0400;
  localparam logic [15:0] MC_RESET       = 16'h0000;
  localparam logic [15:0] XO_RESET       = 16'h0000;
  localparam logic [3:0]  XO_FIXED_LOW   = 4'hB;
  localparam logic [15:0] SM_RESET       = 16'h00E1;
  localparam logic [7:0]  INT_MASK_RESET = 8'h00;
  localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

  // -----------------------------------------------------------------
  // operating modes and advertisement values
  // -----------------------------------------------------------------
  localparam logic [2:0] MODE_10_HALF   = 3'h0;
  localparam logic [2:0] MODE_10_FULL   = 3'h1;
  localparam logic [2:0] MODE_100_HALF  = 3'h2;
  localparam logic [2:0] MODE_100_FULL  = 3'h3;
  localparam logic [2:0] MODE_AN_100H   = 3'h4;
  localparam logic [2:0] MODE_REPEATER  = 3'h5;
  localparam logic [2:0] MODE_RESERVED  = 3'h6;
  localparam logic [2:0] MODE_ALL       = 3'h7;
  localparam logic [3:0] ADV_100_HALF   = 4'h4;
  localparam logic [3:0] ADV_ALL        = 4'hF;
  localparam logic [3:0] ADV_NONE       = 4'h0;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam longint CLK_HZ          = 25000000;
  localparam longint ENERGY_QUIET_MS = 256;
  localparam longint ENERGY_QUIET_CYCLES = (ENERGY_QUIET_MS * CLK_HZ) / 1000;

  // -----------------------------------------------------------------
  // state of the register bank
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  modeSync1;
    logic [2:0]  modeSync2;
    logic [4:0]  addrSync1;
    logic [4:0]  addrSync2;
    logic        xoSync1;
    logic        xoSync2;
    logic [1:0]  strapCnt;
    logic        strapDone;
    logic [15:0] modeCtl;
    logic [15:0] specialModes;
    logic [15:0] xover;
    logic [7:0]  intMask;
    logic        expFault;
    logic        expPage;
    logic [7:1]  intFlags;
    logic        prevEnergy;
    logic        prevAnDone;
    logic        prevLinkUp;
    logic [15:0] rdData;
    logic        autonegEnable;
    logic        speed100;
    logic        fullDuplex;
    logic [3:0]  advertise;
    logic        repeaterMode;
    logic        crsOnTransmit;
    logic        crossoverAuto;
    logic        crossoverSwap;
    logic        irq;
  } pms_state_t;

endpackage

// ---- pms_energy_monitor.sv ----
// line energy monitor with quiet timeout
`timescale 1ns/10ps
`default_nettype none
module pms_energy_monitor #(
  parameter longint QUIET_CYCLES = pms_pkg::ENERGY_QUIET_CYCLES,
  parameter int     CNT_W        = 23
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // line side
  input  wire logic lineEnergy,
  // status
  output logic      energyPresent
);

  typedef struct packed {
    logic [CNT_W-1:0] quietCnt;
    logic             present;
  } pms_energy_t;

  localparam logic [CNT_W-1:0] QUIET_LAST = CNT_W'(QUIET_CYCLES - 1);

  pms_energy_t s;
  pms_energy_t next_s;

  if (QUIET_CYCLES < 2 || QUIET_CYCLES > (64'h1 << CNT_W))
  begin : g_check
    $error("quiet count does not fit the counter");
  end

  // -----------------------------------------------------------------
  // quiet timer
  // -----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    if (lineEnergy)
    begin
      next_s.quietCnt = '0;
      next_s.present  = 1'b1;
    end
    else if (s.quietCnt == QUIET_LAST)
    begin
      next_s.present = 1'b0;
    end
    else
    begin
      next_s.quietCnt = s.quietCnt + CNT_W'(1);
    end
  end

  // software reset does not reach here, so the flag survives it
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s.quietCnt <= '0;
      s.present  <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign energyPresent = s.present;

endmodule // pms_energy_monitor
`default_nettype wire

// ---- pms_phy_mode_status_regs.sv ----
// mode, crossover, energy and interrupt flag registers of the transceiver
`timescale 1ns/10ps
`default_nettype none
module pms_phy_mode_status_regs #(
  parameter longint ENERGY_QUIET_CYCLES = pms_pkg::ENERGY_QUIET_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        softReset,
  // management register port
  input  wire logic [4:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [15:0] regWrData,
  input  wire logic        regRdEn,
  output logic      [15:0] regRdData,
  // configuration straps
  input  wire logic [2:0]  modeStrap,
  input  wire logic [4:0]  addrStrap,
  input  wire logic        crossover_auto_strap,
  // negotiation and line status
  input  wire logic        parallelDetectFault,
  input  wire logic        pageReceived,
  input  wire logic        partnerAnAble,
  input  wire logic        partnerNextPageAble,
  input  wire logic        autonegComplete,
  input  wire logic        remoteFault,
  input  wire logic        linkUp,
  input  wire logic        partnerAcknowledge,
  input  wire logic        lineEnergy,
  input  wire logic        tenbase_polarity_reversed,
  // controls to the transceiver
  output logic             energy_detect_powerdown_enable,
  output logic             energy_present,
  output logic      [4:0]  mgmt_station_address,
  output logic             autonegEnable,
  output logic             speed100,
  output logic             fullDuplex,
  output logic      [3:0]  advertise,
  output logic             repeaterMode,
  output logic             crsOnTransmit,
  output logic             crossoverAuto,
  output logic             crossoverSwap,
  output logic             rx_pll_reference_lock,
  // interrupt
  output logic             irq
);

  localparam int CNT_W = $clog2(ENERGY_QUIET_CYCLES + 1);

  pms_pkg::pms_state_t s;
  pms_pkg::pms_state_t next_s;
  logic                energyNow;
  logic [15:0]         expView;
  logic [15:0]         mcView;
  logic [15:0]         xoView;
  logic [15:0]         intView;
  logic [15:0]         readMux;
  logic                wrMc;
  logic                wrSm;
  logic                wrXo;
  logic                wrMask;
  logic                rdExp;
  logic                rdInt;
  logic [2:0]          modeCode;
  logic [7:1]          intCause;

  // -----------------------------------------------------------------
  // energy monitor
  // -----------------------------------------------------------------
  pms_energy_monitor #(
    .QUIET_CYCLES (ENERGY_QUIET_CYCLES),
    .CNT_W        (CNT_W)
  ) u_energy (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .lineEnergy    (lineEnergy),
    .energyPresent (energyNow)
  );

  // -----------------------------------------------------------------
  // register decode and read views
  // -----------------------------------------------------------------
  assign wrMc   = regWrEn && (regAddr == pms_pkg::IDX_MODE_CONTROL);
  assign wrSm   = regWrEn && (regAddr == pms_pkg::IDX_SPECIAL_MODES);
  assign wrXo   = regWrEn && (regAddr == pms_pkg::IDX_CROSSOVER);
  assign wrMask = regWrEn && (regAddr == pms_pkg::IDX_INT_MASK);
  assign rdExp  = regRdEn && (regAddr == pms_pkg::IDX_AN_EXPANSION);
  assign rdInt  = regRdEn && (regAddr == pms_pkg::IDX_INT_SOURCE);

  always_comb
  begin
    expView = 16'h0000;
    expView[pms_pkg::EXP_PARTNER_AN] = partnerAnAble;
    expView[pms_pkg::EXP_PAGE_RX]    = s.expPage;
    expView[pms_pkg::EXP_LOCAL_NP]   = 1'b0;
    expView[pms_pkg::EXP_PARTNER_NP] = partnerNextPageAble;
    expView[pms_pkg::EXP_PD_FAULT]   = s.expFault;

    mcView = s.modeCtl;
    mcView[pms_pkg::MC_ENERGY] = energyNow;

    xoView = s.xover;
    xoView[pms_pkg::XO_POLARITY] = tenbase_polarity_reversed;
    xoView[3:0] = pms_pkg::XO_FIXED_LOW;

    intView = {8'h00, s.intFlags, 1'b0};

    unique case (regAddr)
      pms_pkg::IDX_AN_EXPANSION:  readMux = expView;
      pms_pkg::IDX_MODE_CONTROL:  readMux = mcView;
      pms_pkg::IDX_SPECIAL_MODES: readMux = s.specialModes;
      pms_pkg::IDX_CROSSOVER:     readMux = xoView;
      pms_pkg::IDX_INT_SOURCE:    readMux = intView;
      pms_pkg::IDX_INT_MASK:      readMux = {8'h00, s.intMask};
      default:                    readMux = 16'h0000;
    endcase
  end

  // -----------------------------------------------------------------
  // interrupt causes
  // -----------------------------------------------------------------
  always_comb
  begin
    intCause = '0;
    intCause[pms_pkg::INT_ENERGY]       = energyNow && !s.prevEnergy;
    intCause[pms_pkg::INT_AN_DONE]      = autonegComplete && !s.prevAnDone;
    intCause[pms_pkg::INT_REMOTE_FAULT] = remoteFault;
    intCause[pms_pkg::INT_LINK_DOWN]    = !linkUp && s.prevLinkUp;
    intCause[pms_pkg::INT_PARTNER_ACK]  = partnerAcknowledge;
    intCause[pms_pkg::INT_PD_FAULT]     = parallelDetectFault;
    intCause[pms_pkg::INT_PAGE_RX]      = pageReceived;
  end

  assign modeCode = s.specialModes[pms_pkg::SM_MODE_LSB +: 3];

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    next_s = s;

    // strap pins pass two flops before use
    next_s.modeSync1 = modeStrap;
    next_s.modeSync2 = s.modeSync1;
    next_s.addrSync1 = addrStrap;
    next_s.addrSync2 = s.addrSync1;
    next_s.xoSync1   = crossover_auto_strap;
    next_s.xoSync2   = s.xoSync1;

    next_s.prevEnergy = energyNow;
    next_s.prevAnDone = autonegComplete;
    next_s.prevLinkUp = linkUp;

    // register writes
    if (wrMc)
    begin
      next_s.modeCtl = (s.modeCtl & ~pms_pkg::MC_WRITE_MASK)
                     | (regWrData & pms_pkg::MC_WRITE_MASK);
    end
    if (wrSm)
    begin
      next_s.specialModes = regWrData;
    end
    if (wrXo)
    begin
      next_s.xover = (s.xover & ~pms_pkg::XO_WRITE_MASK)
                   | (regWrData & pms_pkg::XO_WRITE_MASK);
    end
    if (wrMask)
    begin
      next_s.intMask = regWrData[7:0];
    end

    // latched flags: a cause in the read cycle keeps the flag set
    next_s.expFault = (s.expFault && !rdExp) || parallelDetectFault;
    next_s.expPage  = (s.expPage && !rdExp) || pageReceived;
    next_s.intFlags = (s.intFlags & {7{!rdInt}}) | intCause;

    // software reset clears mode control, mask, crossover except its kept field, and flags but new causes; special modes stay
    if (softReset)
    begin
      next_s.modeCtl  = pms_pkg::MC_RESET;
      next_s.xover    = (s.xover & pms_pkg::XO_KEPT_MASK)
                      | (pms_pkg::XO_RESET & ~pms_pkg::XO_KEPT_MASK);
      next_s.intMask  = pms_pkg::INT_MASK_RESET;
      next_s.expFault = parallelDetectFault;
      next_s.expPage  = pageReceived;
      next_s.intFlags = intCause;
    end

    // strap capture once the synchronisers have settled
    if (!s.strapDone)
    begin
      if (s.strapCnt == pms_pkg::STRAP_SETTLE)
      begin
        next_s.strapDone = 1'b1;
        next_s.specialModes[pms_pkg::SM_MODE_LSB +: 3] = s.modeSync2;
        next_s.specialModes[pms_pkg::SM_ADDR_LSB +: 5] = s.addrSync2;
      end
      else
      begin
        next_s.strapCnt = s.strapCnt + 2'h1;
      end
    end

    // read data, captured with the pre-clear flag values
    if (regRdEn)
    begin
      next_s.rdData = readMux;
    end

    // operating mode decode
    unique case (modeCode)
      pms_pkg::MODE_10_HALF, pms_pkg::MODE_10_FULL,
      pms_pkg::MODE_100_HALF, pms_pkg::MODE_100_FULL:
      begin
        next_s.autonegEnable = 1'b0;
        next_s.speed100      = modeCode[1];
        next_s.fullDuplex    = modeCode[0];
        next_s.advertise     = pms_pkg::ADV_NONE;
        next_s.repeaterMode  = 1'b0;
      end
      pms_pkg::MODE_AN_100H, pms_pkg::MODE_REPEATER:
      begin
        next_s.autonegEnable = 1'b1;
        next_s.speed100      = 1'b1;
        next_s.fullDuplex    = 1'b0;
        next_s.advertise     = pms_pkg::ADV_100_HALF;
        next_s.repeaterMode  = (modeCode == pms_pkg::MODE_REPEATER);
      end
      pms_pkg::MODE_RESERVED, pms_pkg::MODE_ALL:
      begin
        // reserved code behaves as all-capable
        next_s.autonegEnable = 1'b1;
        next_s.speed100      = 1'b1;
        next_s.fullDuplex    = 1'b1;
        next_s.advertise     = pms_pkg::ADV_ALL;
        next_s.repeaterMode  = 1'b0;
      end
    endcase
    next_s.crsOnTransmit = (modeCode == pms_pkg::MODE_10_HALF)
                        || (modeCode == pms_pkg::MODE_100_HALF)
                        || (modeCode == pms_pkg::MODE_AN_100H)
                        || (modeCode == pms_pkg::MODE_RESERVED)
                        || (modeCode == pms_pkg::MODE_ALL);

    // crossover selection
    if (s.xover[pms_pkg::XO_OVERRIDE])
    begin
      next_s.crossoverAuto = s.xover[pms_pkg::XO_AUTO];
      next_s.crossoverSwap = !s.xover[pms_pkg::XO_AUTO]
                          && s.xover[pms_pkg::XO_SWAP];
    end
    else
    begin
      next_s.crossoverAuto = s.xoSync2;
      next_s.crossoverSwap = 1'b0;
    end

    next_s.irq = |({s.intFlags, 1'b0} & s.intMask);
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s               <= '0;
      s.modeCtl       <= pms_pkg::MC_RESET;
      s.specialModes  <= pms_pkg::SM_RESET;
      s.xover         <= pms_pkg::XO_RESET;
      s.intMask       <= pms_pkg::INT_MASK_RESET;
      s.prevEnergy    <= 1'b1;
      s.autonegEnable <= 1'b1;
      s.speed100      <= 1'b1;
      s.fullDuplex    <= 1'b1;
      s.advertise     <= pms_pkg::ADV_ALL;
      s.crsOnTransmit <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign regRdData                      = s.rdData;
  assign energy_detect_powerdown_enable = s.modeCtl[pms_pkg::MC_EDPD];
  assign energy_present                 = energyNow;
  assign mgmt_station_address           = s.specialModes[pms_pkg::SM_ADDR_LSB +: 5];
  assign autonegEnable                  = s.autonegEnable;
  assign speed100                       = s.speed100;
  assign fullDuplex                     = s.fullDuplex;
  assign advertise                      = s.advertise;
  assign repeaterMode                   = s.repeaterMode;
  assign crsOnTransmit                  = s.crsOnTransmit;
  assign crossoverAuto                  = s.crossoverAuto;
  assign crossoverSwap                  = s.crossoverSwap;
  assign rx_pll_reference_lock          = s.xover[pms_pkg::XO_PLL_REF];
  assign irq                            = s.irq;

endmodule // pms_phy_mode_status_regs
`default_nettype wire

// ---- pms_regs_monitor.sv ----
// assertion checker of the mode and status register bank
`timescale 1ns/10ps
`default_nettype none
module pms_regs_monitor #(
  parameter longint ENERGY_QUIET_CYCLES = pms_pkg::ENERGY_QUIET_CYCLES
) (
  // clock, reset and register port
  input wire logic clk_sys, reset_n, softReset, regWrEn, regRdEn,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData, regRdData,
  // line status
  input wire logic partnerAnAble, partnerNextPageAble, pageReceived, parallelDetectFault,
  input wire logic remoteFault, partnerAcknowledge, lineEnergy, tenbase_polarity_reversed,
  // controls
  input wire logic energy_detect_powerdown_enable, energy_present, autonegEnable, speed100, fullDuplex,
  input wire logic repeaterMode, crsOnTransmit, crossoverAuto, crossoverSwap, rx_pll_reference_lock, irq,
  input wire logic [4:0] mgmt_station_address,
  input wire logic [3:0] advertise
);
  localparam logic [8:0] MODE_OUT [8] = '{9'h001, 9'h040, 9'h081, 9'h0C0, 9'h191, 9'h192, 9'h1FD, 9'h1FD};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [2:0] upCnt;
  logic [31:0] quiet;
  logic [1:0] pendX;
  logic [3:0] pendI;
  wire [3:0] lv = {remoteFault, partnerAcknowledge, parallelDetectFault, pageReceived};
  wire rd6 = regRdEn && regAddr == 5'h06;
  wire rd29 = regRdEn && regAddr == 5'h1D;
  always_ff @(posedge clk_sys)
  begin
    upCnt <= !reset_n ? 3'h0 : upCnt + {2'h0, upCnt != 3'h7};
    quiet <= (!reset_n || lineEnergy) ? 32'h0 : quiet + 32'h1;
    pendX <= !reset_n ? 2'h0 : ((softReset || rd6) ? lv[1:0] : pendX | lv[1:0]);
    pendI <= !reset_n ? 4'h0 : ((softReset || rd29) ? lv : pendI | lv);
  end
  sequence wr_s(logic [4:0] a);
    regWrEn && regAddr == a && !softReset && upCnt == 3'h7;
  endsequence
  sequence hold_s(logic [4:0] a);
    !(regWrEn && regAddr == a) && !softReset;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  mode_decode_a: assert property (
    wr_s(5'h12) ##1 hold_s(5'h12) |=> {autonegEnable, speed100, fullDuplex, advertise, repeaterMode,
    crsOnTransmit} == MODE_OUT[$past(regWrData[7:5], 2)]) else $error("mode decode wrong");
  station_addr_a: assert property (
    wr_s(5'h12) |=> mgmt_station_address == $past(regWrData[4:0])) else $error("address not taken");
  powerdown_a: assert property (
    wr_s(5'h11) |=> energy_detect_powerdown_enable == $past(regWrData[13])) else $error("powerdown bit");
  pll_lock_a: assert property (
    wr_s(5'h1B) |=> rx_pll_reference_lock == $past(regWrData[10])) else $error("pll lock bit");
  crossover_a: assert property (
    wr_s(5'h1B) ##0 regWrData[15] ##1 hold_s(5'h1B) |=> crossoverAuto == $past(regWrData[14], 2)
    && crossoverSwap == $past(regWrData[13] && !regWrData[14], 2)) else $error("crossover decode wrong");
  exp_read_a: assert property (
    rd6 |=> regRdData[15:5] == 11'h000 && !regRdData[2] && regRdData[0] == $past(partnerAnAble)
    && regRdData[3] == $past(partnerNextPageAble)) else $error("expansion read wrong");
  exp_latch_a: assert property (
    rd6 && !softReset |=> {regRdData[4], regRdData[1]} == $past(pendX)) else $error("expansion latch wrong");
  int_latch_a: assert property (
    rd29 && !softReset |=> {regRdData[5], regRdData[3:1]} == $past(pendI)) else $error("flag latch wrong");
  fixed_bits_a: assert property (
    regRdEn && regAddr == 5'h1B |=> regRdData[4:0] == {$past(tenbase_polarity_reversed), 4'hB})
    else $error("fixed bits wrong");
  energy_rise_a: assert property (
    lineEnergy |=> energy_present) else $error("energy not seen");
  energy_fall_a: assert property (
    $fell(energy_present) |-> quiet + 2 >= ENERGY_QUIET_CYCLES && quiet <= ENERGY_QUIET_CYCLES + 2)
    else $error("energy fell at wrong time");
  mask_off_a: assert property (
    wr_s(5'h1E) ##0 regWrData[7:0] == 8'h00 ##1 hold_s(5'h1E) |=> !irq) else $error("masked irq");
endmodule // pms_regs_monitor
bind pms_phy_mode_status_regs pms_regs_monitor #(.ENERGY_QUIET_CYCLES(ENERGY_QUIET_CYCLES)) i_mon (.*);
`default_nettype wire

// ---- pms_mgmt_model.sv ----
// station management controller issuing register reads and writes
`timescale 1ns/10ps
`default_nettype none
module pms_mgmt_model (
  // clock and read data
  input  wire logic        clk_sys,
  input  wire logic [15:0] regRdData,
  // request
  output logic      [4:0]  regAddr,
  output logic             regWrEn,
  output logic             regRdEn,
  output logic      [15:0] regWrData
);
  initial
  begin
    regAddr = 5'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    if (a == 5'h12 && d[7:5] == 3'h6) d[7:5] = 3'h7;
    if (a == 5'h1B && d[15:13] == 3'h7) d[13] = 1'b0;
    if (a == 5'h11) d = d & 16'h2000;
    @(negedge clk_sys);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk_sys);
    regWrEn = 1'b0;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk_sys);
    regRdEn = 1'b0;
    d = regRdData;
  endtask
endmodule // pms_mgmt_model
`default_nettype wire

// ---- test_phy_mode_status_regs.sv ----
// self-checking testbench of the mode and status register bank
`timescale 1ns/10ps
`default_nettype none
module test_phy_mode_status_regs;
  localparam logic [8:0] MODE_OUT [8] = '{9'h001, 9'h040, 9'h081, 9'h0C0, 9'h191, 9'h192, 9'h1FD, 9'h1FD};
  logic clk_sys = 1'b0, reset_n = 1'b0, softReset = 1'b0, regWrEn, regRdEn;
  logic [4:0] regAddr, mgmt_station_address, addrStrap = 5'h0A;
  logic [15:0] regWrData, regRdData;
  logic [2:0] modeStrap = 3'h4;
  logic [3:0] advertise;
  logic crossover_auto_strap = 1'b1, parallelDetectFault = 1'b0, pageReceived = 1'b0, partnerAnAble = 1'b1;
  logic partnerNextPageAble = 1'b0, autonegComplete = 1'b0, remoteFault = 1'b0, linkUp = 1'b1;
  logic partnerAcknowledge = 1'b0, lineEnergy = 1'b0, tenbase_polarity_reversed = 1'b1;
  logic energy_detect_powerdown_enable, energy_present, autonegEnable, speed100, fullDuplex;
  logic repeaterMode, crsOnTransmit, crossoverAuto, crossoverSwap, rx_pll_reference_lock, irq;
  int err_count = 0;
  int checks = 0;
  pms_phy_mode_status_regs #(.ENERGY_QUIET_CYCLES(16)) i_dut (.*);
  pms_mgmt_model i_mgmt (.*);
  initial forever #20 clk_sys = ~clk_sys;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic rdChk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_mgmt.rd(a, d);
    chk(d, e);
  endtask
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic testReset();
    rdChk(5'h11, 16'h0002);
    rdChk(5'h1B, 16'h001B);
    rdChk(5'h06, 16'h0001);
    rdChk(5'h1D, 16'h0000);
    rdChk(5'h1E, 16'h0000);
    rdChk(5'h12, 16'h008A);
    rdChk(5'h00, 16'h0000);
    chk({11'h0, mgmt_station_address}, 16'h000A);
  endtask
  task automatic testModes();
    for (int m = 0; m < 8; m++)
    begin
      if (m != 6)
      begin
        i_mgmt.wr(5'h12, {8'h00, 3'(m), 5'h05});
        repeat (2) @(negedge clk_sys);
        chk({7'h0, autonegEnable, speed100, fullDuplex, advertise, repeaterMode, crsOnTransmit},
            {7'h0, MODE_OUT[m]});
      end
    end
    chk({11'h0, mgmt_station_address}, 16'h0005);
  endtask
  task automatic testXover();
    logic [15:0] wv [4] = '{16'h0000, 16'h8000, 16'hA41F, 16'hC000};
    logic [2:0] ev [4] = '{3'h4, 3'h0, 3'h3, 3'h4};
    for (int i = 0; i < 4; i++)
    begin
      i_mgmt.wr(5'h1B, wv[i]);
      repeat (2) @(negedge clk_sys);
      chk({13'h0, crossoverAuto, crossoverSwap, rx_pll_reference_lock}, {13'h0, ev[i]});
      rdChk(5'h1B, (wv[i] & 16'hFFE0) | 16'h001B);
    end
  endtask
  task automatic testEvents();
    chk({15'h0, energy_present}, 16'h0000);
    i_mgmt.wr(5'h1E, 16'h00FE);
    {pageReceived, parallelDetectFault, remoteFault, partnerAcknowledge} = 4'hF;
    {linkUp, autonegComplete, lineEnergy} = 3'h3;
    @(negedge clk_sys);
    {pageReceived, parallelDetectFault, remoteFault, partnerAcknowledge, lineEnergy} = 5'h00;
    chk({15'h0, energy_present}, 16'h0001);
    repeat (2) @(negedge clk_sys);
    chk({15'h0, irq}, 16'h0001);
    i_mgmt.wr(5'h1E, 16'h0000);
    repeat (2) @(negedge clk_sys);
    chk({15'h0, irq}, 16'h0000);
    rdChk(5'h06, 16'h0013);
    rdChk(5'h06, 16'h0001);
    rdChk(5'h1D, 16'h00FE);
    rdChk(5'h1D, 16'h0000);
  endtask
  task automatic testSoft();
    repeat (16) @(negedge clk_sys);
    i_mgmt.wr(5'h11, 16'h2000);
    chk({15'h0, energy_detect_powerdown_enable}, 16'h0001);
    i_mgmt.wr(5'h1B, 16'h8400);
    i_mgmt.wr(5'h1E, 16'h00FF);
    i_mgmt.wr(5'h12, 16'h0065);
    @(negedge clk_sys);
    softReset = 1'b1;
    @(negedge clk_sys);
    softReset = 1'b0;
    rdChk(5'h11, 16'h0000);
    rdChk(5'h1B, 16'h041B);
    rdChk(5'h1E, 16'h0000);
    rdChk(5'h12, 16'h0065);
    lineEnergy = 1'b0;
    repeat (24) @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    chk({15'h0, energy_present}, 16'h0001);
    repeat (6) @(negedge clk_sys);
    rdChk(5'h12, 16'h008A);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    testReset();
    testModes();
    testXover();
    testEvents();
    testSoft();
    finish_test();
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    finish_test();
  end
endmodule // test_phy_mode_status_regs
`default_nettype wire
